/* blpm_pkg.sv */
// Package of constants and types for the backlight PWM mode control block
package blpm_pkg;
    // APB register offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_BRT    = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_DUTY   = 8'h0c;
    // Control register field positions
    localparam int CTRL_BL_ON   = 0;
    localparam int CTRL_BOOST   = 1;
    localparam int CTRL_SRC_LO  = 2;
    localparam int CTRL_PHASE   = 4;
    localparam int CTRL_RES_LO  = 5;
    localparam int CTRL_SYNC_EN = 7;
    localparam logic [7:0] CTRL_RESET = 8'h02;
    localparam logic [7:0] BRT_RESET  = 8'hff;
    // Timing
    localparam int CLK_HZ      = 40_000_000;
    localparam int OSC_HZ      = 5_000_000;
    localparam int OSC_DIV     = CLK_HZ / OSC_HZ;
    localparam int INIT_US     = 2000;
    localparam int SOFT_US     = 4000;
    localparam int INIT_TICKS  = INIT_US * (OSC_HZ / 1_000_000);
    localparam int SOFT_TICKS  = SOFT_US * (OSC_HZ / 1_000_000);
    localparam int DUTY_W      = 13;
    localparam int LOCK_W      = 13;
    // Brightness sources
    typedef enum logic [1:0] {
        SRC_PIN0   = 2'b00,
        SRC_PIN1   = 2'b01,
        SRC_REG    = 2'b10,
        SRC_DIRECT = 2'b11
    } blpm_src_t;
    // Operating modes
    typedef enum logic [2:0] {
        MODE_RESET   = 3'b000,
        MODE_STANDBY = 3'b001,
        MODE_STARTUP = 3'b010,
        MODE_BOOST   = 3'b011,
        MODE_NORMAL  = 3'b100
    } blpm_mode_t;
    // Status outputs carried together
    typedef struct packed {
        logic       fault;
        logic       boost_on;
        logic       low_current;
        logic       nvm_load;
        blpm_mode_t mode;
    } blpm_stat_t;
endpackage

/* blpm_core.sv */
// Mode control, clock generation and brightness selection of the backlight driver
// Notes on behaviour
// - In reset mode every internal register holds its default value.
// - Power-on reset release moves the block from reset into standby.
// - Standby only when backlight bit low, PWM input inactive, no reset.
// - Writes accepted in standby; control bits apply once boost soft-start completes and normal mode is reached.
// - Backlight bit or PWM input high starts startup with a 2 ms wait.
// - Startup loads configuration from the nonvolatile memories.
// - Thermal shutdown holds the block in startup until it clears.
// - Boost soft-start lasts 4 ms in low-current mode, LEDs off.
// - Startup proceeds into boost soft-start only when boost enable is high.
// - Normal mode accepts writes in any order, any bits per write.
// - State machine delays and duty measurement run on the 5 MHz tick.
// - PWM clock is the 5 MHz tick multiplied by the resolution setting until frame-sync lock.
// - Frame-sync lock uses a 13-bit period control value.
// - Before lock the PWM clock comes from the internal oscillator.
// - Missing sync pulses are filled internally; real pulses resume cleanly.
// - Source select: 00/01 input duty, 10 register, 11 direct.
// - Input-duty mode measures a 13-bit duty to drive output PWM.
// - Register mode takes duty from the 8-bit brightness register.
// - Direct mode output follows the sampled input, no slope or dither.
// - No phase staggering while direct mode is selected.
// - Over trip point brightness is reduced; overheat turns outputs off. Direct mode output is not reduced here, only source modes 00, 01 and 10.
// - Faults show in a readable status register and on the fault pin.
// - Duty keeps only the top bits matching output resolution.
//
// The placing of the registers and the APB slave port were left to the implementer.
module blpm_core
    import blpm_pkg::*;
#(
    parameter int INIT_CNT = INIT_TICKS,
    parameter int SOFT_CNT = SOFT_TICKS,
    parameter int MISS_MAX = 3
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             pwm_in,
    input  wire logic             frame_sync,
    input  wire logic             thermal_shutdown_event,
    input  wire logic             temp_trip,
    input  wire logic             fault_detect,
    input  wire logic [7:0]       nvm_ctrl,
    output logic      [3:0]       led_pwm,
    output logic                  boost_en,
    output logic                  boost_low_current,
    output logic                  fault_n,
    output blpm_pkg::blpm_stat_t  status
);
    import blpm_pkg::*;

    localparam int CW = 16;

    // Sync flops for pins
    logic [1:0] pwm_s_q, vs_s_q, tsd_s_q, trip_s_q, flt_s_q;
    logic       vs_d1_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_s_q  <= 2'b00;
            vs_s_q   <= 2'b00;
            vs_d1_q  <= 1'b0;
            tsd_s_q  <= 2'b00;
            trip_s_q <= 2'b00;
            flt_s_q  <= 2'b00;
        end else begin
            pwm_s_q  <= {pwm_s_q[0], pwm_in};
            vs_s_q   <= {vs_s_q[0], frame_sync};
            vs_d1_q  <= vs_s_q[1];
            tsd_s_q  <= {tsd_s_q[0], thermal_shutdown_event};
            trip_s_q <= {trip_s_q[0], temp_trip};
            flt_s_q  <= {flt_s_q[0], fault_detect};
        end
    end
    wire logic pwm_i  = pwm_s_q[1];
    wire logic tsd_i  = tsd_s_q[1];
    wire logic vs_rise = vs_s_q[1] & ~vs_d1_q;

    // 5 MHz oscillator tick from divider
    logic [3:0] osc_cnt_q;
    logic       tick_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_q <= 4'h0;
            tick_q    <= 1'b0;
        end else begin
            tick_q    <= (osc_cnt_q == 4'(OSC_DIV - 1));
            osc_cnt_q <= (osc_cnt_q == 4'(OSC_DIV - 1)) ? 4'h0 : osc_cnt_q + 4'h1;
        end
    end

    // Mode state
    blpm_mode_t mode_q;
    logic [7:0] ctrl_q, brt_q, cfg_q;
    logic [15:0] wait_q;
    wire logic bl_on    = ctrl_q[CTRL_BL_ON];
    wire logic start_rq = bl_on | pwm_i;

    // Mode sequencing; the delays are counted only on oscillator ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_RESET;
            wait_q <= 16'h0000;
        end else begin
            case (mode_q)
                MODE_RESET: begin
                    mode_q <= MODE_STANDBY;
                end
                MODE_STANDBY: begin
                    wait_q <= 16'h0000;
                    if (start_rq) mode_q <= MODE_STARTUP;
                end
                MODE_STARTUP: begin
                    if (tsd_i) begin
                        wait_q <= 16'h0000;
                    end else if (wait_q < 16'(INIT_CNT)) begin
                        if (tick_q) wait_q <= wait_q + 16'h0001;
                    end else if (!start_rq) begin
                        mode_q <= MODE_STANDBY;
                    end else if (cfg_q[CTRL_BOOST]) begin
                        mode_q <= MODE_BOOST;
                        wait_q <= 16'h0000;
                    end
                end
                MODE_BOOST: begin
                    if (tsd_i) begin
                        mode_q <= MODE_STARTUP;
                        wait_q <= 16'h0000;
                    end else if (wait_q < 16'(SOFT_CNT)) begin
                        if (tick_q) wait_q <= wait_q + 16'h0001;
                    end else begin
                        mode_q <= MODE_NORMAL;
                    end
                end
                MODE_NORMAL: begin
                    wait_q <= 16'h0000;
                    if (tsd_i) mode_q <= MODE_STARTUP;
                    else if (!start_rq) mode_q <= MODE_STANDBY;
                end
                default: mode_q <= MODE_RESET;
            endcase
        end
    end

    // Configuration image; loaded from nonvolatile bits during startup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= CTRL_RESET;
        end else if (mode_q == MODE_STARTUP) begin
            cfg_q <= nvm_ctrl | (ctrl_q & 8'h01);
        end else if (mode_q == MODE_NORMAL) begin
            cfg_q <= ctrl_q;
        end
    end

    // APB slave: zero wait, unmapped address flags an error
    wire logic acc = psel & penable;
    wire logic hit = (paddr == ADDR_CTRL) | (paddr == ADDR_BRT) |
                     (paddr == ADDR_STATUS) | (paddr == ADDR_DUTY);
    logic [12:0] duty_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
            brt_q  <= BRT_RESET;
        end else if (acc && pwrite && mode_q != MODE_RESET) begin
            // Any field may change in one write, in any order
            if (paddr == ADDR_CTRL) ctrl_q <= pwdata[7:0];
            if (paddr == ADDR_BRT)  brt_q  <= pwdata[7:0];
        end
    end
    // Read data latched in the setup cycle so it stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b1;
            pslverr <= psel & ~penable & ~hit;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    ADDR_CTRL:   prdata <= {24'h0, ctrl_q};
                    ADDR_BRT:    prdata <= {24'h0, brt_q};
                    ADDR_STATUS: prdata <= {25'h0, status};
                    ADDR_DUTY:   prdata <= {19'h0, duty_q};
                    default:     prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Input duty measurement in oscillator ticks
    // A pin held steady gives no edge, so the last measured duty is kept
    logic [CW-1:0] hi_cnt_q, per_cnt_q;
    logic          pwm_d1_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt_q  <= '0;
            per_cnt_q <= '0;
            pwm_d1_q  <= 1'b0;
            duty_q    <= 13'h0000;
        end else if (tick_q) begin
            pwm_d1_q <= pwm_i;
            if (pwm_i && !pwm_d1_q) begin
                // Period ends at rising edge; scale high time to 13 bits
                if (per_cnt_q != '0)
                    duty_q <= 13'(({16'h0, hi_cnt_q} << 13) / {16'h0, per_cnt_q});
                hi_cnt_q  <= 16'h0001;
                per_cnt_q <= 16'h0001;
            end else begin
                if (per_cnt_q != '1) per_cnt_q <= per_cnt_q + 16'h0001;
                if (pwm_i && hi_cnt_q != '1) hi_cnt_q <= hi_cnt_q + 16'h0001;
            end
        end
    end

    // Frame-sync period lock with fill-in of missing pulses
    // Lock needs two equal periods in ticks; a period off the tick grid locks only when two successive tick counts match
    logic [LOCK_W-1:0] lock_per_q, lock_cnt_q;
    logic [1:0]        miss_q;
    logic              locked_q, sync_tick_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_per_q  <= '0;
            lock_cnt_q  <= '0;
            miss_q      <= 2'b00;
            locked_q    <= 1'b0;
            sync_tick_q <= 1'b0;
        end else begin
            sync_tick_q <= 1'b0;
            if (!cfg_q[CTRL_SYNC_EN]) begin
                locked_q <= 1'b0;
            end else if (vs_rise) begin
                // Real pulse restarts the period count without a short cycle
                locked_q    <= (lock_cnt_q == lock_per_q) && lock_per_q != '0;
                lock_per_q  <= lock_cnt_q;
                lock_cnt_q  <= '0;
                miss_q      <= 2'b00;
                sync_tick_q <= 1'b1;
            end else if (tick_q) begin
                if (locked_q && lock_cnt_q == lock_per_q) begin
                    lock_cnt_q  <= '0;
                    sync_tick_q <= 1'b1;
                    if (miss_q == 2'(MISS_MAX)) locked_q <= 1'b0;
                    else miss_q <= miss_q + 2'b01;
                end else if (lock_cnt_q != '1) begin
                    lock_cnt_q <= lock_cnt_q + 13'h0001;
                end
            end
        end
    end

    // PWM clock: oscillator tick times the resolution multiplier while not locked
    logic [2:0] mul_q;
    logic       pwm_clk_q;
    wire  logic [2:0] mul_top = 3'((4'h1 << cfg_q[CTRL_RES_LO +: 2]) - 4'h1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mul_q     <= 3'h0;
            pwm_clk_q <= 1'b0;
        end else begin
            mul_q     <= (mul_q == 3'h7) ? 3'h0 : mul_q + 3'h1;
            // Locked: oscillator tick plus sync ticks, no multiplier; otherwise multiplied internal oscillator drives
            pwm_clk_q <= locked_q ? (sync_tick_q | tick_q)
                                  : ((mul_q & ~mul_top) == 3'h0) || tick_q;
        end
    end

    // Brightness selection and resolution trimming
    function automatic logic [12:0] trim(input logic [12:0] v, input logic [1:0] r);
        trim = v & ~13'((14'h1 << (3'h2 - 3'(r[1])) * 2 - (r[0] ? 1 : 0)) - 14'h1);
    endfunction
    logic [12:0] sel_duty;
    always_comb begin
        case (blpm_src_t'(cfg_q[CTRL_SRC_LO +: 2]))
            SRC_REG:    sel_duty = {brt_q, brt_q[7:3]};
            SRC_PIN0,
            SRC_PIN1:   sel_duty = duty_q;
            default:    sel_duty = 13'h0000;
        endcase
        if (trip_s_q[1]) sel_duty = {1'b0, sel_duty[12:1]};
        sel_duty = trim(sel_duty, cfg_q[CTRL_RES_LO +: 2]);
    end

    // Output PWM counter and outputs
    logic [12:0] pwm_cnt_q;
    wire  logic  run    = (mode_q == MODE_NORMAL) && !tsd_i;
    wire  logic  direct = (cfg_q[CTRL_SRC_LO +: 2] == 2'b11);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_cnt_q <= 13'h0000;
            led_pwm   <= 4'h0;
        end else begin
            if (pwm_clk_q) pwm_cnt_q <= pwm_cnt_q + 13'h0001;
            for (int i = 0; i < 4; i++) begin
                if (!run) led_pwm[i] <= 1'b0;
                else if (direct) led_pwm[i] <= pwm_i;
                else if (cfg_q[CTRL_PHASE])
                    led_pwm[i] <= (pwm_cnt_q + 13'(i * 2048)) < sel_duty;
                else led_pwm[i] <= pwm_cnt_q < sel_duty;
            end
        end
    end

    // Boost, fault and status outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boost_en          <= 1'b0;
            boost_low_current <= 1'b0;
            fault_n           <= 1'b1;
            status            <= '0;
        end else begin
            boost_en          <= (mode_q == MODE_BOOST || mode_q == MODE_NORMAL) && !tsd_i;
            boost_low_current <= (mode_q == MODE_BOOST);
            fault_n           <= ~(flt_s_q[1] | tsd_i);
            status            <= '{fault: flt_s_q[1] | tsd_i,
                                   boost_on: boost_en,
                                   low_current: boost_low_current,
                                   nvm_load: (mode_q == MODE_STARTUP),
                                   mode: mode_q};
        end
    end

    // Checks
    startup_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == MODE_STARTUP && $past(mode_q) == MODE_STANDBY) |->
        mode_q == MODE_STARTUP [*8])
        else $error("startup left too early");
    tsd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tsd_i && mode_q == MODE_STARTUP) |=> mode_q == MODE_STARTUP)
        else $error("left startup under thermal shutdown");
    boost_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == MODE_BOOST && $past(mode_q) == MODE_STARTUP) |-> $past(cfg_q[CTRL_BOOST]))
        else $error("boost start without enable");
    soft_leds_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(mode_q) == MODE_BOOST |-> led_pwm == 4'h0)
        else $error("leds on in soft start");
    standby_cond_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == MODE_STANDBY && $past(mode_q) == MODE_NORMAL) |-> !$past(start_rq))
        else $error("standby entered while requested on");
    reset_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_q == MODE_RESET |=> mode_q == MODE_STANDBY)
        else $error("reset did not move to standby");
    tick_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick_q |=> !tick_q [*7] ##1 tick_q)
        else $error("oscillator tick spacing wrong");
    fault_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        flt_s_q[1] |=> !fault_n && status.fault)
        else $error("fault not reported");
    direct_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        (run && direct) |=> led_pwm == {4{$past(pwm_i)}})
        else $error("direct mode not following input");
    // Register defaults, shutdown, soft-start current, standby entry, load flag
    reset_defaults_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_q == MODE_RESET |-> ctrl_q == CTRL_RESET && brt_q == BRT_RESET)
        else $error("register not at default in reset mode");
    shutdown_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        tsd_i |=> led_pwm == 4'h0 && !boost_en)
        else $error("outputs on under thermal shutdown");
    soft_current_a: assert property (@(posedge pclk) disable iff (!presetn)
        boost_low_current == ($past(mode_q) == MODE_BOOST))
        else $error("low-current mode outside soft start");
    standby_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == MODE_STANDBY && $past(mode_q) == MODE_STARTUP) |-> !$past(start_rq))
        else $error("standby entered from startup while requested on");
    nvm_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        status.nvm_load == ($past(mode_q) == MODE_STARTUP))
        else $error("load flag does not match startup mode");
endmodule // blpm_core

/* blpm_host_model.sv */
// Host-side stimulus model: PWM input source and frame-sync pulse train
module blpm_host_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pwm_en,
    input  wire logic sync_en,
    output logic      pwm_in,
    output logic      frame_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pwm_cnt_q;
    logic [9:0] sync_cnt_q;
    logic [1:0] pulse_idx_q;

    // PWM source: 100 cycle period, 40 high; held low while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_cnt_q <= 8'h00;
            pwm_in    <= 1'b0;
        end else begin
            pwm_cnt_q <= (pwm_cnt_q == 8'h63) ? 8'h00 : pwm_cnt_q + 8'h01;
            pwm_in    <= pwm_en && (pwm_cnt_q < 8'h28);
        end
    end

    // Sync pulse every 500 cycles; every fourth one left out to exercise fill-in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_cnt_q  <= 10'h000;
            pulse_idx_q <= 2'h0;
            frame_sync  <= 1'b0;
        end else begin
            sync_cnt_q <= (sync_cnt_q == 10'h1f3) ? 10'h000 : sync_cnt_q + 10'h001;
            if (sync_cnt_q == 10'h1f3) begin
                pulse_idx_q <= pulse_idx_q + 2'h1;
            end
            frame_sync <= sync_en && (sync_cnt_q < 10'h004) && (pulse_idx_q != 2'h3);
        end
    end
endmodule // blpm_host_model

/* test_backlight_pwm_mode_control.sv */
// Self-checking testbench of the backlight PWM mode control core
module test_backlight_pwm_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    import blpm_pkg::*;
    localparam int INIT_N = 20;
    localparam int SOFT_N = 40;
    // Host PWM is 40 of 100 cycles high: 5 ticks high in a 12 or 13 tick period
    localparam int DUTY_LO = ((40 / OSC_DIV) << 13) / (100 / OSC_DIV + 1);
    localparam int DUTY_HI = ((40 / OSC_DIV) << 13) / (100 / OSC_DIV);

    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]       paddr = 8'h00;
    logic [31:0]      pwdata = 32'h0, prdata;
    logic             pready, pslverr, pwm_in, frame_sync, boost_en, boost_low_current;
    logic             thermal_shutdown_event = 1'b0, fault_detect = 1'b0;
    logic             pwm_en = 1'b0, sync_en = 1'b0, fault_n;
    logic [7:0]       nvm_ctrl = 8'h02;
    logic [3:0]       led_pwm;
    blpm_stat_t       status;
    logic [31:0]      rd;
    logic             err;
    int               mismatches = 0, checks = 0, len;

    always #12.5 pclk = ~pclk;

    blpm_core #(.INIT_CNT(INIT_N), .SOFT_CNT(SOFT_N), .MISS_MAX(3)) u_blpm_core (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_in(pwm_in), .frame_sync(frame_sync),
        .thermal_shutdown_event(thermal_shutdown_event), .temp_trip(1'b0),
        .fault_detect(fault_detect), .nvm_ctrl(nvm_ctrl), .led_pwm(led_pwm),
        .boost_en(boost_en), .boost_low_current(boost_low_current), .fault_n(fault_n),
        .status(status));

    blpm_host_model u_blpm_host_model (
        .pclk(pclk), .presetn(presetn), .pwm_en(pwm_en), .sync_en(sync_en),
        .pwm_in(pwm_in), .frame_sync(frame_sync));

    // Compare and count; an unknown bit matches only an unknown expected bit
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // One APB transfer: setup, access until pready, then release
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Cycles spent in one mode, bounded by lim
    task automatic time_in(input blpm_mode_t m, input int lim);
        len = 0;
        while (status.mode === m && len < lim) begin
            @(posedge pclk);
            len++;
        end
    endtask

    // Wait for a mode under a bounded count
    task automatic wait_mode(input blpm_mode_t m, input int lim);
        len = 0;
        while (status.mode !== m && len < lim) begin
            @(posedge pclk);
            len++;
        end
        check({29'h0, status.mode}, {29'h0, m}, "mode not reached");
    endtask

    task automatic do_reset(input logic [7:0] nvm);
        presetn  <= 1'b0;
        nvm_ctrl <= nvm;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog: the whole run needs well under 8000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        do_reset(8'h02);
        // Defaults after power-on release
        check({29'h0, status.mode}, {29'h0, MODE_STANDBY}, "not standby");
        check({28'h0, led_pwm}, 32'h0, "leds on at reset");
        check({31'h0, fault_n}, 32'h1, "fault pin at reset");
        check({31'h0, pready}, 32'h1, "ready idle");
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, {24'h0, CTRL_RESET}, "ctrl default");
        check({31'h0, err}, 32'h0, "mapped read error");
        apb(1'b0, ADDR_BRT, 32'h0);
        check(rd, {24'h0, BRT_RESET}, "brt default");
        apb(1'b0, 8'h10, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped no error");
        check(rd, 32'h0, "unmapped read data");
        $display("test reset done");

        // Standby writes, then startup and soft start with lengths inside a window, then normal
        apb(1'b1, ADDR_BRT, 32'h40);
        apb(1'b1, ADDR_CTRL, 32'h0b);
        apb(1'b0, ADDR_BRT, 32'h0);
        check(rd, 32'h40, "brt write in standby");
        wait_mode(MODE_STARTUP, 8);
        time_in(MODE_STARTUP, 400);
        check({31'h0, len >= INIT_N * 8 - 8 && len <= INIT_N * 8 + 16}, 32'h1, "init wait");
        check({29'h0, status.mode}, {29'h0, MODE_BOOST}, "no soft start");
        check({31'h0, boost_low_current}, 32'h1, "soft start current");
        check({28'h0, led_pwm}, 32'h0, "leds during soft start");
        time_in(MODE_BOOST, 800);
        check({31'h0, len >= SOFT_N * 8 - 8 && len <= SOFT_N * 8 + 16}, 32'h1, "soft time");
        check({29'h0, status.mode}, {29'h0, MODE_NORMAL}, "not normal");
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h0b, "ctrl readback");
        $display("test startup done");

        // Direct mode with staggering requested: all outputs follow the input
        sync_en <= 1'b1;
        pwm_en  <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h1f);
        repeat (2) begin
            @(posedge pwm_in);
            repeat (8) @(posedge pclk);
            check({28'h0, led_pwm}, 32'hf, "direct high");
            @(negedge pwm_in);
            repeat (8) @(posedge pclk);
            check({28'h0, led_pwm}, 32'h0, "direct low");
        end
        $display("test direct done");

        // Thermal shutdown holds startup with outputs off
        thermal_shutdown_event <= 1'b1;
        wait_mode(MODE_STARTUP, 16);
        repeat (400) @(posedge pclk);
        check({29'h0, status.mode}, {29'h0, MODE_STARTUP}, "left startup");
        check({27'h0, boost_en, led_pwm}, 32'h0, "outputs during shutdown");
        thermal_shutdown_event <= 1'b0;
        wait_mode(MODE_NORMAL, 800);
        apb(1'b0, ADDR_DUTY, 32'h0);
        check({31'h0, rd >= DUTY_LO && rd <= DUTY_HI}, 32'h1, "input duty");
        $display("test thermal done");

        // Fault shows on pin and in status
        fault_detect <= 1'b1;
        repeat (6) @(posedge pclk);
        check({30'h0, fault_n, status.fault}, 32'h1, "fault report");
        fault_detect <= 1'b0;
        $display("test fault done");

        // Boost enable low: soft start never entered
        pwm_en <= 1'b0;
        do_reset(8'h00);
        apb(1'b1, ADDR_CTRL, 32'h01);
        wait_mode(MODE_STARTUP, 8);
        len = 0;
        repeat (600) begin
            @(posedge pclk);
            if (status.mode === MODE_BOOST) len++;
        end
        check(len, 32'h0, "soft start without enable");
        apb(1'b1, ADDR_CTRL, 32'h0);
        wait_mode(MODE_STANDBY, 8);
        $display("test no boost done");
        report_and_stop();
    end
endmodule // test_backlight_pwm_mode_control
